// File: hw/cpg_gate.sv
// Privilege level gate for the setup port command interpreter
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Reset to read level; queries only.
// - Set/test entered only from read level.
// - Set level allows queries and settings.
// - Test level allows everything except level entry commands, which are refused.
// - Fifteen idle minutes return to read level.
// - Setting commands need set or test level.
// - Defaults and receiver reset need test.
// - Tracking receiver overrides operator date.
module cpg_gate #(
  parameter longint unsigned IDLE_LIMIT = cpg_pkg::IDLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic char_valid_i,
  input wire logic [7:0] char_i,
  input wire logic cmd_valid_i,
  input wire cpg_pkg::cpg_cmd_t cmd_i,
  input wire logic cmd_has_value_i,
  input wire logic level_on_i,
  input wire logic tracking_i,
  output logic run_o,
  output logic read_only_o,
  output logic refuse_o,
  output cpg_pkg::cpg_cmd_t run_cmd_o,
  output logic run_write_o,
  output cpg_pkg::cpg_level_t level_o,
  output logic timeout_o
);
  import cpg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Command classing
  // Level commands form their own class so that entry and exit stay explicit

  function automatic cpg_class_t class_of(input cpg_cmd_t c);
    cpg_class_t k;
    k = CPG_CLASS_READ;
    case (c)
      CPG_CMD_RESTORE_DEFS, CPG_CMD_RECEIVER_RESET: k = CPG_CLASS_TEST;
      CPG_CMD_CONFIG_LEVEL, CPG_CMD_TEST_LEVEL: k = CPG_CLASS_LEVEL;
      CPG_CMD_CABLE_DELAY, CPG_CMD_DATE, CPG_CMD_EVENT_OUTPUT, CPG_CMD_PANEL_FORMAT,
      CPG_CMD_FREQUENCY_OUTPUT_CMD_OUTPUT, CPG_CMD_TIMECODE_OUTPUT, CPG_CMD_POSITION,
      CPG_CMD_LOCK_TIMEOUT, CPG_CMD_REMOTE_SETUP, CPG_CMD_SERIAL_SETUP,
      CPG_CMD_SYNC_TIMEOUT, CPG_CMD_TIME: k = CPG_CLASS_SET;
      default: k = CPG_CLASS_READ;
    endcase
    return k;
  endfunction : class_of

  ////////////////////////////////////////////////////////////////////////////////
  // Level and decision

  cpg_level_t lvl_q;
  cpg_level_t lvl_d;
  logic run_q, run_d;
  logic ro_q, ro_d;
  logic ref_q, ref_d;
  logic wr_q, wr_d;
  cpg_cmd_t cmd_q, cmd_d;
  logic to_q, to_d;
  logic expired;
  cpg_class_t cls;

  // Timer only runs above the read level; any keystroke restarts it
  cpg_idle_timer #(
    .LIMIT(IDLE_LIMIT)
  ) u_idle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(lvl_q != CPG_LVL_READ),
    .restart_i(char_valid_i),
    .expired_o(expired)
  );

  always_comb begin
    cls = class_of(cmd_i);
    lvl_d = lvl_q;
    run_d = 1'b0;
    ro_d = 1'b0;
    ref_d = 1'b0;
    wr_d = 1'b0;
    cmd_d = cmd_q;
    to_d = 1'b0;
    if (cmd_valid_i) begin
      cmd_d = cmd_i;
      case (cls)
        CPG_CLASS_READ: begin
          run_d = 1'b1;
        end
        CPG_CLASS_SET: begin
          run_d = 1'b1;
          // Without privilege a setting command only reads back
          wr_d = cmd_has_value_i && (lvl_q != CPG_LVL_READ);
          // Operator date does not stick while tracking
          if (cmd_i == CPG_CMD_DATE && tracking_i) begin
            wr_d = 1'b0;
          end
          ro_d = cmd_has_value_i && !wr_d;
        end
        CPG_CLASS_TEST: begin
          run_d = (lvl_q == CPG_LVL_TEST);
          wr_d = run_d;
          ref_d = !run_d;
        end
        CPG_CLASS_LEVEL: begin
          if (!level_on_i) begin
            run_d = 1'b1;
            lvl_d = CPG_LVL_READ;
          end else if (lvl_q == CPG_LVL_READ) begin
            run_d = 1'b1;
            lvl_d = (cmd_i == CPG_CMD_TEST_LEVEL) ? CPG_LVL_TEST : CPG_LVL_SET;
          end else begin
            ref_d = 1'b1;
          end
        end
        default: ref_d = 1'b1;
      endcase
    end else if (expired && lvl_q != CPG_LVL_READ) begin
      // A late expiry after the level has already dropped is ignored
      lvl_d = CPG_LVL_READ;
      to_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= LVL_RST;
      run_q <= 1'b0;
      ro_q <= 1'b0;
      ref_q <= 1'b0;
      wr_q <= 1'b0;
      cmd_q <= CMD_RST;
      to_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      run_q <= run_d;
      ro_q <= ro_d;
      ref_q <= ref_d;
      wr_q <= wr_d;
      cmd_q <= cmd_d;
      to_q <= to_d;
    end
  end

  assign level_o = lvl_q;
  assign run_o = run_q;
  assign read_only_o = ro_q;
  assign refuse_o = ref_q;
  assign run_write_o = wr_q;
  assign run_cmd_o = cmd_q;
  assign timeout_o = to_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_read_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && lvl_q == CPG_LVL_READ) |=> !run_write_o)
    else $error("write allowed at read level");

  chk_entry_from_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (lvl_q == CPG_LVL_SET && $past(lvl_q) != CPG_LVL_SET && !$past(rst_i))
      |-> $past(lvl_q) == CPG_LVL_READ && $past(cmd_valid_i))
    else $error("set level entered from wrong level");

  chk_set_writes: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && lvl_q == CPG_LVL_SET && cmd_has_value_i
      && cmd_i == CPG_CMD_CABLE_DELAY) |=> run_o && run_write_o)
    else $error("set level failed to write");

  chk_test_all: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && lvl_q == CPG_LVL_TEST && cmd_i != CPG_CMD_CONFIG_LEVEL
      && cmd_i != CPG_CMD_TEST_LEVEL) |=> run_o && !refuse_o)
    else $error("test level refused a command");

  chk_timeout_read: assert property (@(posedge clk_i) disable iff (rst_i)
    timeout_o |-> level_o == CPG_LVL_READ && $past(level_o) != CPG_LVL_READ)
    else $error("timeout without level drop");

  chk_set_cmd_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && cmd_i == CPG_CMD_TIME && lvl_q == CPG_LVL_READ)
      ##1 1'b1 |-> run_o && !run_write_o)
    else $error("setting command wrote at read level");

  chk_test_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && cmd_i == CPG_CMD_RESTORE_DEFS && lvl_q != CPG_LVL_TEST)
      |=> refuse_o && !run_o)
    else $error("defaults ran below test level");

  chk_date_tracking: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && cmd_i == CPG_CMD_DATE && tracking_i) |=> !run_write_o)
    else $error("date written while tracking");

  chk_test_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (lvl_q == CPG_LVL_TEST && $past(lvl_q) != CPG_LVL_TEST && !$past(rst_i))
      |-> $past(lvl_q) == CPG_LVL_READ && $past(cmd_valid_i))
    else $error("test level entered from wrong level");

  chk_level_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && level_on_i && lvl_q != CPG_LVL_READ
      && (cmd_i == CPG_CMD_CONFIG_LEVEL || cmd_i == CPG_CMD_TEST_LEVEL))
      |=> refuse_o && !run_o && $stable(level_o))
    else $error("level entry accepted above read level");

  chk_read_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_valid_i && cmd_i == CPG_CMD_SHOW_VERSION) |=> run_o && !refuse_o && !run_write_o)
    else $error("query not answered");

  chk_write_needs_level: assert property (@(posedge clk_i) disable iff (rst_i)
    run_write_o |-> $past(lvl_q) != CPG_LVL_READ)
    else $error("write without raised level");

  chk_refuse_alone: assert property (@(posedge clk_i) disable iff (rst_i)
    refuse_o |-> !run_o && !run_write_o && !read_only_o)
    else $error("refused command also ran");

  chk_char_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    char_valid_i |=> !expired ##1 !timeout_o)
    else $error("keystroke did not restart idle timer");

endmodule : cpg_gate
`default_nettype wire

// File: hw/cpg_idle_timer.sv
// Inactivity timer that flags expiry after a programmable number of cycles
`timescale 1ns/100ps
`default_nettype none

module cpg_idle_timer #(
  parameter longint unsigned LIMIT = 64'd180_000_000_000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic restart_i,
  output logic expired_o
);
  import cpg_pkg::*;

  logic [39:0] cnt_q;
  logic [39:0] cnt_d;
  logic exp_q;
  logic exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!run_i || restart_i) begin
      cnt_d = '0;
    end else if (cnt_q >= 40'(LIMIT - 1)) begin
      cnt_d = '0;
      exp_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 40'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;

endmodule : cpg_idle_timer
`default_nettype wire

// File: hw/cpg_pkg.sv
// Package of constants and types for the command privilege gate
package cpg_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned IDLE_MINUTES = 15;
  localparam longint unsigned IDLE_CYCLES = longint'(IDLE_MINUTES) * 60 * CLK_HZ;

  localparam int CMD_W = 5;
  localparam logic [7:0] CHAR_ENTER = 8'h0d;

  typedef enum logic [1:0] {
    CPG_LVL_READ = 2'b00,
    CPG_LVL_SET  = 2'b01,
    CPG_LVL_TEST = 2'b10
  } cpg_level_t;

  typedef enum logic [1:0] {
    CPG_CLASS_READ  = 2'b00,
    CPG_CLASS_SET   = 2'b01,
    CPG_CLASS_TEST  = 2'b10,
    CPG_CLASS_LEVEL = 2'b11
  } cpg_class_t;

  typedef enum logic [CMD_W-1:0] {
    CPG_CMD_CABLE_DELAY     = 5'h00,
    CPG_CMD_SHOW_OUTPUT_CFG = 5'h01,
    CPG_CMD_SHOW_ALARM_HIST = 5'h02,
    CPG_CMD_DATE            = 5'h03,
    CPG_CMD_RESTORE_DEFS    = 5'h04,
    CPG_CMD_SHOW_TRACK_HIST = 5'h05,
    CPG_CMD_SHOW_OSC_HIST   = 5'h06,
    CPG_CMD_SHOW_DST_RULES  = 5'h07,
    CPG_CMD_EVENT_OUTPUT    = 5'h08,
    CPG_CMD_PANEL_FORMAT    = 5'h09,
    CPG_CMD_FREQUENCY_OUTPUT_CMD_OUTPUT     = 5'h0a,
    CPG_CMD_SIGNAL_STRENGTH = 5'h0b,
    CPG_CMD_HELP            = 5'h0c,
    CPG_CMD_TIMECODE_OUTPUT = 5'h0d,
    CPG_CMD_POSITION        = 5'h0e,
    CPG_CMD_LOCK_TIMEOUT    = 5'h0f,
    CPG_CMD_REMOTE_SETUP    = 5'h10,
    CPG_CMD_RECEIVER_RESET  = 5'h11,
    CPG_CMD_SERIAL_SETUP    = 5'h12,
    CPG_CMD_CONFIG_LEVEL    = 5'h13,
    CPG_CMD_SHOW_STATUS     = 5'h14,
    CPG_CMD_SYNC_TIMEOUT    = 5'h15,
    CPG_CMD_TIME            = 5'h16,
    CPG_CMD_TEST_LEVEL      = 5'h17,
    CPG_CMD_SHOW_VERSION    = 5'h18
  } cpg_cmd_t;

  // Values after reset
  localparam cpg_level_t LVL_RST = CPG_LVL_READ;
  localparam cpg_cmd_t CMD_RST = CPG_CMD_SHOW_STATUS;

endpackage : cpg_pkg

// File: verification/cpg_operator.sv
// Operator terminal model that types characters and command lines
`timescale 1ns/100ps
`default_nettype none

module cpg_operator
  import cpg_pkg::*;
(
  input wire logic clk_i,
  output var logic char_valid_o,
  output var logic [7:0] char_o,
  output var logic cmd_valid_o,
  output var cpg_pkg::cpg_cmd_t cmd_o,
  output var logic has_value_o,
  output var logic level_on_o
);
  initial begin
    char_valid_o = 1'b0;
    char_o = 8'h00;
    cmd_valid_o = 1'b0;
    cmd_o = CPG_CMD_HELP;
    has_value_o = 1'b0;
    level_on_o = 1'b0;
  end

  // One keystroke; the released character lines show a changing pattern
  task automatic key(input logic [7:0] c);
    @(posedge clk_i) #1 char_valid_o = 1'b1;
    char_o = c;
    @(posedge clk_i) #1 char_valid_o = 1'b0;
    char_o = ~c;
  endtask : key

  // Enter key, then the decoded line is presented for one cycle
  task automatic line(input cpg_cmd_t c, input logic v, input logic on);
    key(CHAR_ENTER);
    cmd_valid_o = 1'b1;
    cmd_o = c;
    has_value_o = v;
    level_on_o = on;
    @(posedge clk_i) #1 cmd_valid_o = 1'b0;
    cmd_o = cpg_cmd_t'(~c);
    has_value_o = ~v;
    level_on_o = ~on;
  endtask : line
endmodule : cpg_operator

`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the privilege level gate
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import cpg_pkg::*;
  localparam logic [6:0] RUN = 7'h40, RO = 7'h20, REF = 7'h10, WR = 7'h08, TO = 7'h04;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tracking_i = 1'b0;
  logic char_valid, cmd_valid, has_value, level_on;
  logic [7:0] char_v;
  cpg_cmd_t cmd, run_cmd_o;
  logic run_o, read_only_o, refuse_o, run_write_o, timeout_o;
  cpg_level_t level_o;
  int err_total = 0;
  int comparisons = 0;
  int n;

  always #2.5 clk_i = ~clk_i;

  cpg_operator u_op (.clk_i(clk_i), .char_valid_o(char_valid), .char_o(char_v),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd), .has_value_o(has_value), .level_on_o(level_on));

  cpg_gate #(.IDLE_LIMIT(64'd50)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .char_valid_i(char_valid), .char_i(char_v), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .cmd_has_value_i(has_value), .level_on_i(level_on), .tracking_i(tracking_i),
    .run_o(run_o), .read_only_o(read_only_o), .refuse_o(refuse_o), .run_cmd_o(run_cmd_o),
    .run_write_o(run_write_o), .level_o(level_o), .timeout_o(timeout_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Level commands are judged without the write flag
  task automatic cmd_t(input cpg_cmd_t c, input logic v, input logic on,
                       input logic [6:0] exp, input logic [6:0] m = 7'h7f);
    u_op.line(c, v, on);
    chk({run_o, read_only_o, refuse_o, run_write_o, timeout_o, level_o} & m, exp);
  endtask : cmd_t

  task automatic t_read();
    chk({run_o, read_only_o, refuse_o, run_write_o, timeout_o, level_o}, 7'h00);
    chk({2'h0, run_cmd_o}, 7'h14);
    cmd_t(CPG_CMD_SHOW_VERSION, 1'b0, 1'b0, RUN);
    cmd_t(CPG_CMD_CABLE_DELAY, 1'b1, 1'b0, RUN | RO);
    cmd_t(CPG_CMD_TIME, 1'b1, 1'b0, RUN | RO);
    cmd_t(CPG_CMD_RESTORE_DEFS, 1'b0, 1'b0, REF);
    cmd_t(CPG_CMD_RECEIVER_RESET, 1'b0, 1'b0, REF);
  endtask : t_read

  task automatic t_set();
    cpg_cmd_t s[11] = '{CPG_CMD_CABLE_DELAY, CPG_CMD_EVENT_OUTPUT, CPG_CMD_PANEL_FORMAT,
      CPG_CMD_FREQUENCY_OUTPUT_CMD_OUTPUT, CPG_CMD_TIMECODE_OUTPUT, CPG_CMD_POSITION, CPG_CMD_LOCK_TIMEOUT,
      CPG_CMD_REMOTE_SETUP, CPG_CMD_SERIAL_SETUP, CPG_CMD_SYNC_TIMEOUT, CPG_CMD_TIME};
    cmd_t(CPG_CMD_CONFIG_LEVEL, 1'b0, 1'b1, RUN | 7'h01, 7'h77);
    chk({2'h0, run_cmd_o}, 7'h13);
    foreach (s[i]) cmd_t(s[i], 1'b1, 1'b0, RUN | WR | 7'h01);
    cmd_t(CPG_CMD_SHOW_ALARM_HIST, 1'b0, 1'b0, RUN | 7'h01);
    cmd_t(CPG_CMD_RESTORE_DEFS, 1'b0, 1'b0, REF | 7'h01);
    cmd_t(CPG_CMD_TEST_LEVEL, 1'b0, 1'b1, REF | 7'h01, 7'h77);
    tracking_i = 1'b1;
    cmd_t(CPG_CMD_DATE, 1'b1, 1'b0, RUN | RO | 7'h01);
    tracking_i = 1'b0;
    cmd_t(CPG_CMD_DATE, 1'b1, 1'b0, RUN | WR | 7'h01);
  endtask : t_set

  task automatic t_test();
    cmd_t(CPG_CMD_CONFIG_LEVEL, 1'b0, 1'b0, RUN, 7'h77);
    cmd_t(CPG_CMD_TEST_LEVEL, 1'b0, 1'b1, RUN | 7'h02, 7'h77);
    cmd_t(CPG_CMD_RESTORE_DEFS, 1'b0, 1'b0, RUN | WR | 7'h02);
    cmd_t(CPG_CMD_RECEIVER_RESET, 1'b0, 1'b0, RUN | WR | 7'h02);
    cmd_t(CPG_CMD_SERIAL_SETUP, 1'b1, 1'b0, RUN | WR | 7'h02);
    cmd_t(CPG_CMD_SHOW_STATUS, 1'b0, 1'b0, RUN | 7'h02);
    cmd_t(CPG_CMD_CONFIG_LEVEL, 1'b0, 1'b1, REF | 7'h02, 7'h77);
  endtask : t_test

  task automatic t_idle();
    repeat (3) begin
      repeat (40) @(posedge clk_i);
      u_op.key(8'h41);
    end
    chk({5'h00, level_o}, 7'h02);
    n = 0;
    while (timeout_o !== 1'b1 && n < 80) begin
      @(posedge clk_i) #1 n++;
    end
    chk({run_o, read_only_o, refuse_o, run_write_o, timeout_o, level_o}, TO);
    chk({6'h00, n >= 45 && n <= 56}, 7'h01);
  endtask : t_idle

  task automatic final_report();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  initial begin
    #25000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_read();
    t_set();
    t_test();
    t_idle();
    final_report();
  end
endmodule : testbench

`default_nettype wire
